// ---- verification/dpm_spindle_model.sv ----
// behavioural spindle motor answering the power controller's requests
`timescale 1ns/100ps
`default_nettype none
module dpm_spindle_model (
  // clock and motor requests
  input wire logic mclk,
  input wire logic spin_up_req,
  input wire logic spin_down_req,
  // ramp lengths in clock cycles, set by the bench
  input wire logic [7:0] up_dly,
  input wire logic [7:0] dn_dly,
  // motor status
  output logic spin_at_speed,
  output logic spin_stopped
);
  logic [7:0] ramp;
  logic going_up;
  // the motor is already turning at power-on; reset does not stop it
  initial
  begin
    spin_at_speed = 1'b1;
    spin_stopped = 1'b0;
    ramp = 8'h00;
    going_up = 1'b0;
  end
  // a request clears at-speed at once (spin-up clears stopped too); the new status is set only when the ramp has run out, so slow motors stay slow
  always @(posedge mclk)
  begin
    if (spin_up_req)
    begin
      spin_stopped <= 1'b0;
      spin_at_speed <= 1'b0;
      going_up <= 1'b1;
      ramp <= up_dly;
    end
    else if (spin_down_req)
    begin
      spin_at_speed <= 1'b0;
      going_up <= 1'b0;
      ramp <= dn_dly;
    end
    else if (ramp != 8'h00)
    begin
      ramp <= ramp - 8'h01;
      if (ramp == 8'h01)
      begin
        spin_at_speed <= going_up;
        spin_stopped <= !going_up;
      end
    end
  end
endmodule : dpm_spindle_model
`default_nettype wire

// ---- verification/drive_power_mode_control_test.sv ----
// self-checking bench of the drive power mode controller
`timescale 1ns/100ps
`default_nettype none
`include "dpm_defs.svh"
module drive_power_mode_control_test
  import dpm_pkg::*;
;
  // short second keeps every measured timeout inside the run
  localparam int SEC = 10;
  logic mclk, rst_b, soft_reset, cmd_valid, cmd_disk, disk_done;
  logic [7:0] cmd_opcode, cmd_count, count_out, up_dly, dn_dly;
  logic spin_at_speed, spin_stopped, device_busy_flag, host_intrq;
  logic count_valid, spin_up_req, spin_down_req, park_req, circ_off, disk_go;
  dpm_pmode_t power_mode;
  int fail_count, checks_done, i, k, seed;
  logic [7:0] codes [6];
  logic [7:0] ops [10] = '{`DPM_OP_SBY_IMM_A, `DPM_OP_SBY_IMM_B,
    `DPM_OP_IDL_IMM_A, `DPM_OP_IDL_IMM_B, `DPM_OP_SBY_A, `DPM_OP_SBY_B,
    `DPM_OP_IDL_A, `DPM_OP_IDL_B, `DPM_OP_CHK_A, `DPM_OP_CHK_B};

  dpm_ctrl #(.SEC_CYCLES(SEC)) i_dut (.mclk(mclk), .rst_b(rst_b),
    .soft_reset(soft_reset), .cmd_valid(cmd_valid),
    .cmd_opcode(cmd_opcode), .cmd_count(cmd_count), .cmd_disk(cmd_disk),
    .disk_done(disk_done), .spin_at_speed(spin_at_speed),
    .spin_stopped(spin_stopped), .device_busy_flag(device_busy_flag),
    .host_intrq(host_intrq), .count_out(count_out),
    .count_valid(count_valid), .spin_up_req(spin_up_req),
    .spin_down_req(spin_down_req), .park_req(park_req),
    .circ_off(circ_off), .disk_go(disk_go), .power_mode(power_mode));

  dpm_spindle_model i_spindle (.mclk(mclk), .spin_up_req(spin_up_req),
    .spin_down_req(spin_down_req), .up_dly(up_dly), .dn_dly(dn_dly),
    .spin_at_speed(spin_at_speed), .spin_stopped(spin_stopped));

  // 100 MHz clock
  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  task automatic check(input string what, input logic [7:0] seen, exp);
    checks_done++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : end_sim

  // timeout length in seconds for a sector count code
  function automatic int tsec(input logic [7:0] c);
    if (c == 8'h00 || c == 8'hFE)
      return 0;
    if (c <= 8'hF0)
      return c * 5;
    if (c <= 8'hFB)
      return (c - 240) * 1800;
    if (c == 8'hFC)
      return 1260;
    if (c == 8'hFD)
      return 36000;
    return 1275;
  endfunction : tsec

  // one-cycle command strobe launched at a falling edge; returns in c1
  task automatic send(input logic [7:0] op, cnt, input logic dsk);
    cmd_opcode = op;
    cmd_count = cnt;
    cmd_disk = dsk;
    cmd_valid = 1'b1;
    @(negedge mclk);
    cmd_valid = 1'b0;
  endtask : send

  // wait for the motor to finish a ramp before the next command
  task automatic settle;
    int n;
    n = 0;
    while (!(spin_at_speed === 1'b1 || spin_stopped === 1'b1) && n < 100)
    begin
      @(negedge mclk);
      n++;
    end
    @(negedge mclk);
  endtask : settle

  // power command other than sleep, checked in c1 and c2
  task automatic pwr(input logic [7:0] op, cnt);
    logic stp, spd, sby, idl, chk;
    logic [7:0] m;
    stp = spin_stopped;
    spd = spin_at_speed;
    m = 8'(power_mode);
    sby = op inside {8'h94, 8'hE0, 8'h96, 8'hE2};
    idl = op inside {8'h95, 8'hE1, 8'h97, 8'hE3};
    chk = op inside {8'h98, 8'hE5};
    send(op, cnt, 1'b0);
    check("busy set", device_busy_flag, 1'b1);
    check("mode", 8'(power_mode), sby ? 8'(DPM_STANDBY) :
      (idl ? 8'(DPM_IDLE) : m));
    check("spin down", spin_down_req, sby & !stp);
    check("spin up", spin_up_req, idl & stp);
    check("park", park_req, idl);
    if (idl | sby)
      check("circuits off", circ_off, idl);
    if (chk)
      check("check answer", count_out, spd ? 8'hFF : 8'h00);
    check("answer valid", count_valid, chk);
    @(negedge mclk);
    check("busy clear", device_busy_flag, 1'b0);
    check("done irq", host_intrq, 1'b1);
  endtask : pwr

  // cycles from now until the timer drops the drive into standby
  task automatic measure(input int cyc);
    k = 0;
    while (power_mode !== DPM_STANDBY && k < cyc + 20)
    begin
      @(negedge mclk);
      k++;
    end
    check("expiry time", 8'(k >= cyc - 2 && k <= cyc + 6), 8'h01);
  endtask : measure

  // watchdog sized well above the longest timeout sequence
  initial
  begin
    repeat (80000) @(posedge mclk);
    fail_count++;
    $display("mismatch watchdog expected end seen timeout");
    end_sim;
  end

  initial
  begin
    fail_count = 0;
    checks_done = 0;
    rst_b = 1'b0;
    soft_reset = 1'b0;
    cmd_valid = 1'b0;
    cmd_disk = 1'b0;
    disk_done = 1'b0;
    cmd_opcode = 8'h00;
    cmd_count = 8'h00;
    up_dly = 8'h05;
    dn_dly = 8'h05;
    seed = $urandom(77161);
    repeat (4) @(negedge mclk);
    rst_b = 1'b1;
    repeat (3) @(negedge mclk);
    check("mode after reset", 8'(power_mode), 8'(DPM_ACTIVE));
    // every power opcode but sleep once, then a random walk with random motor speed
    for (i = 0; i < 26; i++)
    begin
      up_dly = 8'(3 + $urandom % 10);
      dn_dly = 8'(3 + $urandom % 10);
      pwr(ops[i < 10 ? i : $urandom % 10], 8'h00);
      settle;
    end
    // timeout table with random short codes and the range corners
    codes = '{8'(1 + $urandom % 4), 8'(1 + $urandom % 4), 8'hF0, 8'hF1,
      8'hFC, 8'hFF};
    for (i = 0; i < 6; i++)
    begin
      pwr(i[0] ? `DPM_OP_IDL_A : `DPM_OP_IDL_B, codes[i]);
      measure(tsec(codes[i]) * SEC);
      settle;
    end
    // zero and the reserved code switch the timer off
    for (i = 0; i < 2; i++)
    begin
      pwr(`DPM_OP_IDL_A, i ? 8'hFE : 8'h00);
      repeat (300) @(negedge mclk);
      check("timer off", 8'(power_mode), 8'(DPM_IDLE));
      settle;
    end
    // standby with a timeout: no countdown until back in idle
    pwr(`DPM_OP_SBY_A, 8'h01);
    repeat (100) @(negedge mclk);
    check("held in standby", 8'(power_mode), 8'(DPM_STANDBY));
    pwr(`DPM_OP_CHK_B, 8'h00);
    settle;
    pwr(`DPM_OP_IDL_IMM_A, 8'h00);
    measure(5 * SEC);
    settle;
    pwr(`DPM_OP_IDL_B, 8'h02);
    settle;
    pwr(`DPM_OP_SBY_IMM_B, 8'h00);
    settle;
    pwr(`DPM_OP_IDL_IMM_B, 8'h00);
    measure(10 * SEC);
    settle;
    // disk command from standby waits for speed, completion reloads
    send(8'h20, 8'h00, 1'b1);
    check("busy for speed", device_busy_flag, 1'b1);
    k = 0;
    while (disk_go !== 1'b1 && k < 300)
    begin
      @(negedge mclk);
      k++;
    end
    check("go at speed", spin_at_speed, 1'b1);
    check("disk go", disk_go, 1'b1);
    check("busy released", device_busy_flag, 1'b0);
    cmd_disk = 1'b0;
    repeat (30) @(negedge mclk);
    disk_done = 1'b1;
    @(negedge mclk);
    disk_done = 1'b0;
    measure(10 * SEC);
    settle;
    // any command reloads the full interval
    pwr(`DPM_OP_IDL_A, 8'h02);
    settle;
    repeat (60) @(negedge mclk);
    pwr(`DPM_OP_CHK_A, 8'h00);
    measure(10 * SEC);
    settle;
    // sleep holds busy until the motor stops, then only resets wake it
    pwr(`DPM_OP_IDL_IMM_A, 8'h00);
    settle;
    send(`DPM_OP_SLP_A, 8'h00, 1'b0);
    check("sleep mode", 8'(power_mode), 8'(DPM_SLEEP));
    check("sleep spin down", spin_down_req, 1'b1);
    check("sleep busy", device_busy_flag, 1'b1);
    k = 0;
    while (device_busy_flag === 1'b1 && k < 300)
    begin
      @(negedge mclk);
      k++;
    end
    check("stopped at done", spin_stopped, 1'b1);
    check("sleep irq", host_intrq, 1'b1);
    @(negedge mclk);
    send(`DPM_OP_IDL_IMM_B, 8'h00, 1'b0);
    check("ignored in sleep", 8'(power_mode), 8'(DPM_SLEEP));
    check("no busy in sleep", device_busy_flag, 1'b0);
    soft_reset = 1'b1;
    @(negedge mclk);
    soft_reset = 1'b0;
    check("soft reset wakes", 8'(power_mode), 8'(DPM_ACTIVE));
    check("wake spin up", spin_up_req, 1'b1);
    settle;
    send(`DPM_OP_SLP_B, 8'h00, 1'b0);
    repeat (40) @(negedge mclk);
    rst_b = 1'b0;
    repeat (2) @(negedge mclk);
    rst_b = 1'b1;
    repeat (3) @(negedge mclk);
    check("hard reset wakes", 8'(power_mode), 8'(DPM_ACTIVE));
    end_sim;
  end
endmodule : drive_power_mode_control_test
`default_nettype wire

// ---- verilog/dpm_apd_timer.sv ----
// automatic power-down countdown with one-second prescaler
`timescale 1ns/100ps
`default_nettype none
`include "dpm_defs.svh"
module dpm_apd_timer
  import dpm_pkg::*;
#(
  parameter int unsigned SEC_CYCLES = `DPM_SEC_CYCLES
)(
  // clock and synchronised reset
  input wire logic mclk,
  input wire logic rst_n,
  // controller side
  dpm_tmr_if.tmr tif
);
  logic [7:0] code_q, code_d;
  logic [16:0] sec_q, sec_d;
  logic [26:0] pre_q, pre_d;
  logic exp_q, exp_d;

  // timeout code to seconds; reserved 254 acts as disabled
  function automatic logic [16:0] secs(input logic [7:0] c);
    logic [16:0] r;
    r = 17'h00000;
    if (c == `DPM_CODE_OFF)
      r = 17'h00000;
    else if (c <= `DPM_CODE_STEP_MAX)
      r = 17'(17'(c) * `DPM_SEC_STEP);
    else if (c <= `DPM_CODE_HALF_MAX)
      r = 17'(17'(c - `DPM_CODE_STEP_MAX) * `DPM_SEC_HALF_HOUR);
    else if (c == `DPM_CODE_21M)
      r = `DPM_SEC_21M;
    else if (c == `DPM_CODE_10H)
      r = `DPM_SEC_10H;
    else if (c == `DPM_CODE_21M15)
      r = `DPM_SEC_21M15;
    return r;
  endfunction : secs

  // countdown; a load wins over a reload, both restart the prescaler
  always_comb
  begin
    code_d = code_q;
    sec_d = sec_q;
    pre_d = pre_q;
    exp_d = 1'b0;
    if (tif.load)
    begin
      code_d = tif.code;
      sec_d = secs(tif.code);
      pre_d = 27'h0000000;
    end
    else if (tif.reload)
    begin
      sec_d = secs(code_q);
      pre_d = 27'h0000000;
    end
    else if (tif.run && sec_q != 17'h00000)
    begin
      if (pre_q == 27'(SEC_CYCLES - 1))
      begin
        pre_d = 27'h0000000;
        sec_d = sec_q - 17'h00001;
        exp_d = (sec_q == 17'h00001);
      end
      else
        pre_d = pre_q + 27'h0000001;
    end
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      code_q <= 8'h00;
      sec_q <= 17'h00000;
      pre_q <= 27'h0000000;
      exp_q <= 1'b0;
    end
    else
    begin
      code_q <= code_d;
      sec_q <= sec_d;
      pre_q <= pre_d;
      exp_q <= exp_d;
    end
  end

  assign tif.expire = exp_q;

  property p_code_one;
    @(posedge mclk) disable iff (!rst_n)
    tif.load && tif.code == 8'h01 |=> sec_q == 17'h00005;
  endproperty
  a_code_one: assert property (p_code_one)
    else $error("timeout code 1 does not give five seconds");

  property p_code_252;
    @(posedge mclk) disable iff (!rst_n)
    tif.load && tif.code == 8'hFC |=> sec_q == 17'h004EC;
  endproperty
  a_code_252: assert property (p_code_252)
    else $error("timeout code 252 does not give 21 minutes");

  property p_expire_cause;
    @(posedge mclk) disable iff (!rst_n)
    exp_q |-> $past(sec_q) == 17'h00001 && sec_q == 17'h00000;
  endproperty
  a_expire_cause: assert property (p_expire_cause)
    else $error("power-down expiry without the count reaching zero");
endmodule : dpm_apd_timer
`default_nettype wire

// ---- verilog/dpm_ctrl.sv ----
// drive power mode controller: command decode, busy, spindle requests
`timescale 1ns/100ps
`default_nettype none
`include "dpm_defs.svh"
module dpm_ctrl
  import dpm_pkg::*;
#(
  parameter int unsigned SEC_CYCLES = `DPM_SEC_CYCLES
)(
  // clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // host commands
  input wire logic soft_reset,
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_opcode,
  input wire logic [7:0] cmd_count,
  input wire logic cmd_disk,
  input wire logic disk_done,
  // spindle status
  input wire logic spin_at_speed,
  input wire logic spin_stopped,
  // host status
  output logic device_busy_flag,
  output logic host_intrq,
  output logic [7:0] count_out,
  output logic count_valid,
  // drive actions
  output logic spin_up_req,
  output logic spin_down_req,
  output logic park_req,
  output logic circ_off,
  output logic disk_go,
  output var dpm_pmode_t power_mode
);
  logic rst_meta_q, rst_n_q;
  dpm_pmode_t mode_q, mode_d;
  dpm_seq_t seq_q, seq_d;
  logic busy_q, busy_d, irq_q, irq_d, cv_q, cv_d;
  logic up_q, up_d, dn_q, dn_d, park_q, park_d;
  logic off_q, off_d, go_q, go_d, ld_q, ld_d, rl_q, rl_d;
  logic [7:0] cnt_q, cnt_d, code_q, code_d;
  logic accept;
  dpm_tmr_if tif ();

  // release reset through two flops so the whole block leaves it together
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rst_meta_q <= 1'b0;
      rst_n_q <= 1'b0;
    end
    else
    begin
      rst_meta_q <= 1'b1;
      rst_n_q <= rst_meta_q;
    end
  end

  // two opcodes name each power command
  function automatic logic is_op(input logic [7:0] op, input logic [7:0] a,
    input logic [7:0] b);
    return op == a || op == b;
  endfunction : is_op

  // a command is taken only when idle in sequence and not asleep
  assign accept = cmd_valid && seq_q == DPM_SEQ_READY &&
    mode_q != DPM_SLEEP;

  // command decode and power sequencing
  always_comb
  begin
    mode_d = mode_q;
    seq_d = seq_q;
    busy_d = busy_q;
    cnt_d = cnt_q;
    code_d = code_q;
    off_d = off_q;
    irq_d = 1'b0;
    cv_d = 1'b0;
    up_d = 1'b0;
    dn_d = 1'b0;
    park_d = 1'b0;
    go_d = 1'b0;
    ld_d = 1'b0;
    rl_d = disk_done;
    if (soft_reset)
    begin
      mode_d = DPM_ACTIVE;
      seq_d = DPM_SEQ_READY;
      busy_d = 1'b0;
      off_d = 1'b0;
      up_d = spin_stopped;
    end
    else
    begin
      case (seq_q)
        DPM_SEQ_READY:
        begin
          if (accept)
          begin
            rl_d = 1'b1;
            busy_d = 1'b1;
            seq_d = DPM_SEQ_DONE;
            if (is_op(cmd_opcode, `DPM_OP_SBY_IMM_A, `DPM_OP_SBY_IMM_B))
            begin
              mode_d = DPM_STANDBY;
              dn_d = !spin_stopped;
              off_d = 1'b0;
            end
            else if (is_op(cmd_opcode, `DPM_OP_IDL_IMM_A, `DPM_OP_IDL_IMM_B))
            begin
              mode_d = DPM_IDLE;
              up_d = spin_stopped;
              park_d = 1'b1;
              off_d = 1'b1;
            end
            else if (is_op(cmd_opcode, `DPM_OP_SBY_A, `DPM_OP_SBY_B))
            begin
              mode_d = DPM_STANDBY;
              dn_d = !spin_stopped;
              code_d = cmd_count;
              ld_d = 1'b1;
              off_d = 1'b0;
            end
            else if (is_op(cmd_opcode, `DPM_OP_IDL_A, `DPM_OP_IDL_B))
            begin
              mode_d = DPM_IDLE;
              up_d = spin_stopped;
              code_d = cmd_count;
              ld_d = 1'b1;
              park_d = 1'b1;
              off_d = 1'b1;
            end
            else if (is_op(cmd_opcode, `DPM_OP_CHK_A, `DPM_OP_CHK_B))
            begin
              // a spindle not yet at speed counts as standby
              cv_d = 1'b1;
              cnt_d = (mode_q == DPM_STANDBY || !spin_at_speed) ?
                `DPM_CHK_STANDBY : `DPM_CHK_SPINNING;
            end
            else if (is_op(cmd_opcode, `DPM_OP_SLP_A, `DPM_OP_SLP_B))
            begin
              mode_d = DPM_SLEEP;
              dn_d = !spin_stopped;
              off_d = 1'b0;
              seq_d = DPM_SEQ_WSTOP;
            end
            else if (cmd_disk && !spin_at_speed)
            begin
              up_d = spin_stopped;
              seq_d = DPM_SEQ_WSPEED;
            end
            else
            begin
              // other commands pass straight on to the command engine
              busy_d = 1'b0;
              seq_d = DPM_SEQ_READY;
              go_d = cmd_disk;
              if (cmd_disk)
              begin
                mode_d = DPM_ACTIVE;
                off_d = 1'b0;
              end
            end
          end
          else if (tif.expire && mode_q != DPM_SLEEP)
          begin
            mode_d = DPM_STANDBY;
            dn_d = !spin_stopped;
            off_d = 1'b0;
          end
        end
        DPM_SEQ_DONE:
        begin
          // change is under way; spindle motion is not awaited
          busy_d = 1'b0;
          irq_d = 1'b1;
          seq_d = DPM_SEQ_READY;
        end
        DPM_SEQ_WSTOP:
        begin
          if (spin_stopped)
          begin
            busy_d = 1'b0;
            irq_d = 1'b1;
            seq_d = DPM_SEQ_READY;
          end
        end
        DPM_SEQ_WSPEED:
        begin
          if (spin_at_speed)
          begin
            busy_d = 1'b0;
            go_d = 1'b1;
            mode_d = DPM_ACTIVE;
            off_d = 1'b0;
            seq_d = DPM_SEQ_READY;
          end
          // a spindle caught spinning down would never reach speed
          else
            up_d = spin_stopped && !up_q;
        end
        default:
        begin
          seq_d = DPM_SEQ_READY;
        end
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      mode_q <= DPM_ACTIVE;
      seq_q <= DPM_SEQ_READY;
      busy_q <= 1'b0;
      irq_q <= 1'b0;
      cv_q <= 1'b0;
      cnt_q <= 8'h00;
      code_q <= 8'h00;
      up_q <= 1'b0;
      dn_q <= 1'b0;
      park_q <= 1'b0;
      off_q <= 1'b0;
      go_q <= 1'b0;
      ld_q <= 1'b0;
      rl_q <= 1'b0;
    end
    else
    begin
      mode_q <= mode_d;
      seq_q <= seq_d;
      busy_q <= busy_d;
      irq_q <= irq_d;
      cv_q <= cv_d;
      cnt_q <= cnt_d;
      code_q <= code_d;
      up_q <= up_d;
      dn_q <= dn_d;
      park_q <= park_d;
      off_q <= off_d;
      go_q <= go_d;
      ld_q <= ld_d;
      rl_q <= rl_d;
    end
  end

  // timer runs only in active or idle mode and when no command is in progress
  assign tif.load = ld_q;
  assign tif.reload = rl_q;
  assign tif.code = code_q;
  assign tif.run = (mode_q == DPM_ACTIVE || mode_q == DPM_IDLE) &&
    seq_q == DPM_SEQ_READY;

  dpm_apd_timer #(.SEC_CYCLES(SEC_CYCLES)) u_timer (
    .mclk(mclk),
    .rst_n(rst_n_q),
    .tif(tif)
  );

  assign device_busy_flag = busy_q;
  assign host_intrq = irq_q;
  assign count_out = cnt_q;
  assign count_valid = cv_q;
  assign spin_up_req = up_q;
  assign spin_down_req = dn_q;
  assign park_req = park_q;
  assign circ_off = off_q;
  assign disk_go = go_q;
  assign power_mode = mode_q;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n_q);

  sequence s_busy_then_irq;
    busy_q ##1 (!busy_q && irq_q);
  endsequence

  property p_sby_imm;
    accept && is_op(cmd_opcode, 8'h94, 8'hE0) |=> mode_q == DPM_STANDBY
      && dn_q == !$past(spin_stopped) && $stable(code_q);
  endproperty
  a_sby_imm: assert property (p_sby_imm)
    else $error("standby immediate misbehaved");

  property p_idl_imm;
    accept && is_op(cmd_opcode, 8'h95, 8'hE1) |=> mode_q == DPM_IDLE
      && up_q == $past(spin_stopped) && $stable(code_q) && park_q;
  endproperty
  a_idl_imm: assert property (p_idl_imm)
    else $error("idle immediate misbehaved");

  property p_sby_load;
    accept && is_op(cmd_opcode, 8'h96, 8'hE2) |=>
      code_q == $past(cmd_count) && ld_q && mode_q == DPM_STANDBY;
  endproperty
  a_sby_load: assert property (p_sby_load)
    else $error("standby did not load the timeout");

  property p_no_run_standby;
    mode_q == DPM_STANDBY |-> !tif.run;
  endproperty
  a_no_run_standby: assert property (p_no_run_standby)
    else $error("timer runs in standby");

  property p_chk_standby;
    accept && is_op(cmd_opcode, 8'h98, 8'hE5) && mode_q == DPM_STANDBY
      |=> cv_q && cnt_q == 8'h00;
  endproperty
  a_chk_standby: assert property (p_chk_standby)
    else $error("check power mode did not report standby");

  property p_sleep_stays;
    mode_q == DPM_SLEEP && !soft_reset |=> mode_q == DPM_SLEEP;
  endproperty
  a_sleep_stays: assert property (p_sleep_stays)
    else $error("sleep left without a reset");

  property p_pwr_done;
    accept && !soft_reset && (is_op(cmd_opcode, 8'h94, 8'hE0) ||
      is_op(cmd_opcode, 8'h95, 8'hE1) || is_op(cmd_opcode, 8'h96, 8'hE2) ||
      is_op(cmd_opcode, 8'h97, 8'hE3) || is_op(cmd_opcode, 8'h98, 8'hE5))
      |=> s_busy_then_irq;
  endproperty
  a_pwr_done: assert property (p_pwr_done)
    else $error("power command busy or interrupt timing wrong");

  property p_sleep_busy;
    seq_q == DPM_SEQ_WSTOP && !spin_stopped && !soft_reset |=> busy_q
      && !irq_q;
  endproperty
  a_sleep_busy: assert property (p_sleep_busy)
    else $error("sleep released busy before the spindle stopped");

  property p_speed_wait;
    seq_q == DPM_SEQ_WSPEED && !spin_at_speed && !soft_reset |=> busy_q
      && !go_q;
  endproperty
  a_speed_wait: assert property (p_speed_wait)
    else $error("disk command went ahead before speed");

  property p_expire_standby;
    tif.expire && seq_q == DPM_SEQ_READY && !accept && !soft_reset &&
      mode_q != DPM_SLEEP |=> mode_q == DPM_STANDBY;
  endproperty
  a_expire_standby: assert property (p_expire_standby)
    else $error("timeout did not enter standby");
endmodule : dpm_ctrl
`default_nettype wire

// ---- verilog/dpm_defs.svh ----
// constants of the drive power mode controller
`ifndef DPM_DEFS_SVH
`define DPM_DEFS_SVH
// power mode opcodes, two aliases each
`define DPM_OP_SBY_IMM_A 8'h94
`define DPM_OP_SBY_IMM_B 8'hE0
`define DPM_OP_IDL_IMM_A 8'h95
`define DPM_OP_IDL_IMM_B 8'hE1
`define DPM_OP_SBY_A 8'h96
`define DPM_OP_SBY_B 8'hE2
`define DPM_OP_IDL_A 8'h97
`define DPM_OP_IDL_B 8'hE3
`define DPM_OP_CHK_A 8'h98
`define DPM_OP_CHK_B 8'hE5
`define DPM_OP_SLP_A 8'h99
`define DPM_OP_SLP_B 8'hE6
// check power mode answers
`define DPM_CHK_STANDBY 8'h00
`define DPM_CHK_SPINNING 8'hFF
// timeout code boundaries
`define DPM_CODE_OFF 8'h00
`define DPM_CODE_STEP_MAX 8'hF0
`define DPM_CODE_HALF_MAX 8'hFB
`define DPM_CODE_21M 8'hFC
`define DPM_CODE_10H 8'hFD
`define DPM_CODE_21M15 8'hFF
// timeout lengths in seconds
`define DPM_SEC_STEP 17'h00005
`define DPM_SEC_HALF_HOUR 17'h00708
`define DPM_SEC_21M 17'h004EC
`define DPM_SEC_10H 17'h08CA0
`define DPM_SEC_21M15 17'h004FB
// one second in clock cycles
`define DPM_SEC_NS 1000000000
`define DPM_CLK_NS 10
`define DPM_SEC_CYCLES (`DPM_SEC_NS / `DPM_CLK_NS)
`endif

// ---- verilog/dpm_pkg.sv ----
// types of the drive power mode controller
package dpm_pkg;
  typedef enum logic [1:0] {
    DPM_ACTIVE = 2'b00,
    DPM_IDLE = 2'b01,
    DPM_STANDBY = 2'b10,
    DPM_SLEEP = 2'b11
  } dpm_pmode_t;
  typedef enum logic [1:0] {
    DPM_SEQ_READY = 2'b00,
    DPM_SEQ_DONE = 2'b01,
    DPM_SEQ_WSTOP = 2'b10,
    DPM_SEQ_WSPEED = 2'b11
  } dpm_seq_t;
endpackage : dpm_pkg

// ---- verilog/dpm_tmr_if.sv ----
// link between the power controller and its power-down timer
`timescale 1ns/100ps
`default_nettype none
interface dpm_tmr_if;
  logic load;
  logic reload;
  logic [7:0] code;
  logic run;
  logic expire;
  modport ctrl (output load, output reload, output code, output run,
    input expire);
  modport tmr (input load, input reload, input code, input run,
    output expire);
endinterface : dpm_tmr_if
`default_nettype wire
